// File: dcht_pkg.sv
// Purpose: shared constants and types for the host transfer phase logic
// Assumes: one 50 MHz clock, DMA mode for host-to-buffer data
// Notes:   opcodes compare only the low five bits; flag bits sit above
package dcht_pkg;

  // ----------------------------------------------------------------
  // timing
  // ----------------------------------------------------------------
  localparam int CLK_PERIOD_NS = 20;
  localparam int UNDERRUN_NS = 32000;
  localparam int UNDERRUN_CYC_INT = (UNDERRUN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [10:0] UNDERRUN_CYC = 11'(UNDERRUN_CYC_INT);

  // ----------------------------------------------------------------
  // command layout
  // ----------------------------------------------------------------
  localparam logic [4:0] OP_READ_DATA = 5'h06;
  localparam logic [4:0] OP_READ_DEL = 5'h0c;
  localparam logic [4:0] OP_WRITE_DATA = 5'h05;
  localparam logic [4:0] OP_WRITE_DEL = 5'h09;
  localparam logic [3:0] IDX_SEL = 4'h1;
  localparam logic [3:0] IDX_CYL = 4'h2;
  localparam logic [3:0] IDX_HEAD = 4'h3;
  localparam logic [3:0] IDX_SECT = 4'h4;
  localparam logic [3:0] IDX_SIZE = 4'h5;
  localparam logic [3:0] IDX_FINAL = 4'h6;
  localparam logic [3:0] IDX_LAST = 4'h8;

  // ----------------------------------------------------------------
  // result layout
  // ----------------------------------------------------------------
  localparam logic [2:0] RES_LAST = 3'h6;
  localparam logic [7:0] RES_INVALID = 8'h80;
  localparam logic [1:0] IC_NORMAL = 2'h0;
  localparam logic [1:0] IC_ABNORMAL = 2'h1;
  localparam int ST1_END_BIT = 7;
  localparam int ST1_OVR_BIT = 4;
  localparam logic [15:0] SECTOR_BASE = 16'h0080;

  typedef enum logic [2:0] {
    S_IDLE = 3'b000,
    S_CMD = 3'b001,
    S_PROC = 3'b010,
    S_EXEC_W = 3'b011,
    S_EXEC_R = 3'b100,
    S_RESULT = 3'b101
  } dcht_state_type;

  function automatic logic op_valid(input logic [7:0] b);
    op_valid = (b[4:0] == OP_READ_DATA) || (b[4:0] == OP_READ_DEL) ||
               (b[4:0] == OP_WRITE_DATA) || (b[4:0] == OP_WRITE_DEL);
  endfunction

  function automatic logic op_write(input logic [7:0] b);
    op_write = (b[4:0] == OP_WRITE_DATA) || (b[4:0] == OP_WRITE_DEL);
  endfunction

endpackage

// File: dcht_skid.sv
// Purpose: small valid/ready buffer between the byte buffer and the drive
// Assumes: DEPTH is a power of two
// Notes:   in_ready drops when full, so a drive stall backs up the drain
`timescale 1ns/1ns
module dcht_skid #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 2
) (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
  } dcht_skid_type;

  dcht_skid_type s_reg, s_next;
  logic push, pop;

  assign in_ready_o = (s_reg.cnt != (AW+1)'(DEPTH));
  assign out_valid_o = (s_reg.cnt != '0);
  assign out_data_o = s_reg.mem[s_reg.rp];
  assign push = in_valid_i && in_ready_o;
  assign pop = out_valid_o && out_ready_i;

  always_comb begin
    s_next = s_reg;
    if (push) begin
      s_next.mem[s_reg.wp] = in_data_i;
      s_next.wp = s_reg.wp + 1'b1;
    end
    if (pop) begin
      s_next.rp = s_reg.rp + 1'b1;
    end
    s_next.cnt = s_reg.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end
endmodule // dcht_skid

// File: dcht_top.sv
// Purpose: command, execution and result phase logic of a disk controller
// Assumes: host bytes and DMA pins are synchronous to CLK_I
// Notes:   read commands only wait for the drive side to finish
`timescale 1ns/1ns
// Function
// - raise DMA request at once when a host-to-buffer DMA command executes
// - keep request until buffer full, re-raise at threshold occupancy
// - drop request when end count is seen while grant is active
// - drop request on grant or strobe edge of the final byte
// - end transfer by end count, underrun, overrun or final sector number
// - finish a partial final sector internally as if end count arrived
// - implicit ends report abnormal status, end count ends do not
// - sector counted done when last byte drains; request may linger meanwhile
// - raise interrupt at start of result phase, except after an invalid command
// - after last result byte: ready 1, direction 0, busy cleared
// - take command bytes only in command phase; check first byte valid
// - invalid first byte: direction, busy and ready all 1
// - invalid command returns one result byte 80H then command phase
// - read commands: opcode flags, select byte, then C H R N final sector
// - read execution leaves the host interface idle until results
// - read results: three status bytes then C H R N
// - threshold field is service byte count minus one
module dcht_top
  import dcht_pkg::*;
#(
  parameter int FIFO_DEPTH = 16
) (
  input wire logic CLK_I,
  input wire logic RST_N_I,
  input wire logic HOST_WR_I,
  input wire logic [7:0] HOST_DATA_I,
  input wire logic HOST_RD_I,
  output logic [7:0] RES_DATA_O,
  output logic HOST_SERVICE_READY_O,
  output logic TRANSFER_DIRECTION_O,
  output logic COMMAND_IN_PROGRESS_O,
  output logic INT_O,
  output logic DMA_REQUEST_OUT_O,
  input wire logic DMA_GRANT_N_I,
  input wire logic DMA_WR_N_I,
  input wire logic [7:0] DMA_DATA_I,
  input wire logic TRANSFER_END_COUNT_I,
  input wire logic [3:0] BUFFER_THRESHOLD_FIELD_I,
  input wire logic READ_DONE_I,
  output logic [7:0] DRV_DATA_O,
  output logic DRV_VALID_O,
  input wire logic DRV_READY_I
);
  localparam int AW = $clog2(FIFO_DEPTH);
  localparam logic [AW:0] FULL = (AW+1)'(FIFO_DEPTH);

  // ----------------------------------------------------------------
  // state
  // ----------------------------------------------------------------
  typedef struct packed {
    dcht_state_type st;
    logic [3:0] idx;
    logic [7:0] last;
    logic wr_op;
    logic [2:0] hd;
    logic [7:0] c;
    logic [7:0] h;
    logic [7:0] r;
    logic [7:0] n;
    logic [7:0] final_sector_number;
    logic [FIFO_DEPTH-1:0][7:0] fifo;
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic req;
    logic fill;
    logic endcnt_seen;
    logic ovr;
    logic unr;
    logic final_hit;
    logic inv;
    logic intr;
    logic wr_prev;
    logic [15:0] byte_cnt;
    logic [10:0] idle;
    logic [2:0] res_idx;
    logic [7:0] res_data;
  } dcht_ctl_type;

  dcht_ctl_type s_reg, s_next;
  logic endcnt_now, dma_take, in_valid, in_ready, drain, last_sec, to_res;
  logic [7:0] push_data;
  logic [15:0] sec_len, need;

  function automatic logic [7:0] res_sel(input dcht_ctl_type t, input logic [2:0] i);
    logic [1:0] ic;
    ic = (t.ovr || t.unr || t.final_hit) ? IC_ABNORMAL : IC_NORMAL;
    case (i)
      3'h0: res_sel = t.inv ? RES_INVALID : {ic, 3'h0, t.hd};
      3'h1: res_sel = {t.final_hit, 2'h0, t.ovr || t.unr, 4'h0};
      3'h2: res_sel = 8'h00;
      3'h3: res_sel = t.c;
      3'h4: res_sel = t.h;
      3'h5: res_sel = t.r;
      default: res_sel = t.n;
    endcase
  endfunction

  // ----------------------------------------------------------------
  // data path and request gating
  // ----------------------------------------------------------------
  assign sec_len = SECTOR_BASE << s_reg.n[2:0];
  assign last_sec = (s_reg.r == s_reg.final_sector_number);
  assign need = sec_len - s_reg.byte_cnt - 16'(s_reg.cnt);
  assign endcnt_now = (s_reg.st == S_EXEC_W) && !DMA_GRANT_N_I && TRANSFER_END_COUNT_I;
  // byte taken on strobe fall under grant
  assign dma_take = (s_reg.st == S_EXEC_W) && !s_reg.fill && !DMA_GRANT_N_I &&
                    s_reg.wr_prev && !DMA_WR_N_I;
  // pad with zeros once the host is done
  assign in_valid = (s_reg.st == S_EXEC_W) && ((s_reg.cnt != '0) || s_reg.fill);
  assign drain = in_valid && in_ready;
  assign push_data = (s_reg.cnt != '0) ? s_reg.fifo[s_reg.rp] : 8'h00;

  // final byte drops request on grant or strobe
  assign DMA_REQUEST_OUT_O = (s_reg.st == S_EXEC_W) && s_reg.req &&
                             (!last_sec || (need > 16'h0001) ||
                              ((need == 16'h0001) && DMA_GRANT_N_I && DMA_WR_N_I));
  assign HOST_SERVICE_READY_O = (s_reg.st == S_IDLE) || (s_reg.st == S_CMD) ||
                                (s_reg.st == S_RESULT);
  assign TRANSFER_DIRECTION_O = (s_reg.st == S_RESULT);
  assign COMMAND_IN_PROGRESS_O = (s_reg.st != S_IDLE);
  assign INT_O = s_reg.intr;
  assign RES_DATA_O = s_reg.res_data;

  // ----------------------------------------------------------------
  // next state
  // ----------------------------------------------------------------
  always_comb begin
    s_next = s_reg;
    to_res = 1'b0;
    s_next.wr_prev = DMA_WR_N_I;
    case (s_reg.st)
      S_IDLE, S_CMD: begin
        if (HOST_WR_I) begin
          s_next.last = HOST_DATA_I;
          s_next.st = S_PROC;
        end
      end
      S_PROC: begin
        s_next.st = S_CMD;
        s_next.idx = s_reg.idx + 4'h1;
        if (s_reg.idx == 4'h0) begin
          s_next.wr_op = op_write(s_reg.last);
          // invalid code goes straight to one result byte
          if (!op_valid(s_reg.last)) begin
            s_next.inv = 1'b1;
            s_next.st = S_RESULT;
            to_res = 1'b1;
          end
        end else if (s_reg.idx == IDX_SEL) begin
          s_next.hd = s_reg.last[2:0];
        end else if (s_reg.idx == IDX_CYL) begin
          s_next.c = s_reg.last;
        end else if (s_reg.idx == IDX_HEAD) begin
          s_next.h = s_reg.last;
        end else if (s_reg.idx == IDX_SECT) begin
          s_next.r = s_reg.last;
        end else if (s_reg.idx == IDX_SIZE) begin
          s_next.n = s_reg.last;
        end else if (s_reg.idx == IDX_FINAL) begin
          s_next.final_sector_number = s_reg.last;
        end else if (s_reg.idx == IDX_LAST) begin
          s_next.st = s_reg.wr_op ? S_EXEC_W : S_EXEC_R;
          s_next.req = s_reg.wr_op;
          s_next.idx = 4'h0;
        end
      end
      S_EXEC_R: begin
        // interface idle until drive side reports done
        if (READ_DONE_I) begin
          s_next.st = S_RESULT;
          s_next.intr = 1'b1;
          to_res = 1'b1;
        end
      end
      S_EXEC_W: begin
        if (dma_take) begin
          // write into a full buffer is an overrun
          if (s_reg.cnt == FULL) begin
            s_next.ovr = 1'b1;
            s_next.fill = 1'b1;
          end else begin
            s_next.fifo[s_reg.wp] = DMA_DATA_I;
            s_next.wp = s_reg.wp + 1'b1;
          end
        end
        s_next.cnt = s_reg.cnt + (AW+1)'(dma_take && (s_reg.cnt != FULL)) -
                     (AW+1)'(drain && (s_reg.cnt != '0));
        if (drain && (s_reg.cnt != '0)) begin
          s_next.rp = s_reg.rp + 1'b1;
        end
        if (endcnt_now) begin
          s_next.endcnt_seen = 1'b1;
          s_next.fill = 1'b1;
        end
        // host silence while starved is an underrun
        if ((s_reg.cnt == '0) && !s_reg.fill && !dma_take) begin
          s_next.idle = s_reg.idle + 11'h001;
          if (s_reg.idle == UNDERRUN_CYC - 11'h001) begin
            s_next.unr = 1'b1;
            s_next.fill = 1'b1;
          end
        end else begin
          s_next.idle = '0;
        end
        if (s_next.fill) begin
          s_next.req = 1'b0;
        end else if (s_next.cnt == FULL) begin
          s_next.req = 1'b0;
        end else if (s_next.cnt <= (AW+1)'(BUFFER_THRESHOLD_FIELD_I) + (AW+1)'(1)) begin
          // field plus one is the service level
          s_next.req = 1'b1;
        end
        // sector done only when its last byte drains
        if (drain) begin
          s_next.byte_cnt = s_reg.byte_cnt + 16'h0001;
          if (s_reg.byte_cnt == sec_len - 16'h0001) begin
            s_next.byte_cnt = '0;
            if (s_reg.fill || s_next.fill || last_sec) begin
              // final-sector end without end count is abnormal
              s_next.final_hit = last_sec && !s_next.endcnt_seen;
              s_next.st = S_RESULT;
              s_next.intr = 1'b1;
              s_next.cnt = '0;
              s_next.req = 1'b0;
              to_res = 1'b1;
            end else begin
              s_next.r = s_reg.r + 8'h01;
            end
          end
        end
      end
      S_RESULT: begin
        if (HOST_RD_I) begin
          s_next.intr = 1'b0;
          if (s_reg.inv || (s_reg.res_idx == RES_LAST)) begin
            s_next = '0;
            s_next.wr_prev = DMA_WR_N_I;
          end else begin
            s_next.res_idx = s_reg.res_idx + 3'h1;
            s_next.res_data = res_sel(s_reg, s_reg.res_idx + 3'h1);
          end
        end
      end
      default: s_next.st = S_IDLE;
    endcase
    // result data ready with the interrupt
    if (to_res) begin
      s_next.res_idx = '0;
      s_next.res_data = res_sel(s_next, 3'h0);
    end
  end

  always_ff @(posedge CLK_I or negedge RST_N_I) begin
    if (!RST_N_I) begin
      s_reg <= '0;
    end else begin
      s_reg <= s_next;
    end
  end

  // two-entry stage toward the drive; its ready stalls the drain
  dcht_skid #(.WIDTH(8), .DEPTH(2)) u_skid (
    .clk_i(CLK_I),
    .rst_n_i(RST_N_I),
    .in_valid_i(in_valid),
    .in_ready_o(in_ready),
    .in_data_i(push_data),
    .out_valid_o(DRV_VALID_O),
    .out_ready_i(DRV_READY_I),
    .out_data_o(DRV_DATA_O)
  );

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  default clocking clk_cb @(posedge CLK_I); endclocking
  default disable iff (!RST_N_I);

  sequence last_read_seq;
    (s_reg.st == S_RESULT) && HOST_RD_I && (s_reg.inv || s_reg.res_idx == RES_LAST);
  endsequence
  sequence bad_cmd_seq;
    (s_reg.st == S_PROC) && (s_reg.idx == 4'h0) && !op_valid(s_reg.last);
  endsequence

  a_exec_req_start: assert property (
    (s_reg.st == S_EXEC_W) && ($past(s_reg.st) == S_PROC) |-> s_reg.req)
    else $error("request not raised at execution start");
  a_full_req_drop: assert property (
    (s_reg.st == S_EXEC_W) && (s_reg.cnt == FULL) |-> !DMA_REQUEST_OUT_O)
    else $error("request active with full buffer");
  a_thr_req_rearm: assert property (
    (s_reg.st == S_EXEC_W) && $past(s_reg.st == S_EXEC_W) && !s_reg.fill && !s_reg.cnt[AW] &&
    (s_reg.cnt <= (AW+1)'(BUFFER_THRESHOLD_FIELD_I) + (AW+1)'(1)) |-> s_reg.req)
    else $error("request not raised at threshold");
  a_endcnt_req_drop: assert property (
    endcnt_now |=> !DMA_REQUEST_OUT_O [*2])
    else $error("request kept after end count");
  a_last_byte_drop: assert property (
    (s_reg.st == S_EXEC_W) && last_sec && (need == 16'h0001) && !DMA_GRANT_N_I
    |-> !DMA_REQUEST_OUT_O)
    else $error("request kept on final byte grant");
  a_endcnt_status_normal: assert property (
    (s_reg.st == S_RESULT) && (s_reg.res_idx == 3'h0) && !s_reg.inv && s_reg.endcnt_seen &&
    !s_reg.ovr && !s_reg.unr |-> RES_DATA_O[7:6] == IC_NORMAL)
    else $error("end count reported abnormal");
  a_int_result_start: assert property (
    $rose(s_reg.st == S_RESULT) && !s_reg.inv |-> INT_O && TRANSFER_DIRECTION_O)
    else $error("result phase without interrupt");
  a_ready_after_res: assert property (
    last_read_seq |=> HOST_SERVICE_READY_O && !TRANSFER_DIRECTION_O &&
    !COMMAND_IN_PROGRESS_O)
    else $error("not ready after last result");
  a_invalid_result: assert property (
    bad_cmd_seq |=> (RES_DATA_O == RES_INVALID) && HOST_SERVICE_READY_O &&
    TRANSFER_DIRECTION_O && COMMAND_IN_PROGRESS_O)
    else $error("invalid command not reported");
  a_read_exec_idle: assert property (
    (s_reg.st == S_EXEC_R) |-> !DMA_REQUEST_OUT_O && !HOST_SERVICE_READY_O && !INT_O)
    else $error("interface active during read execution");
endmodule // dcht_top

// File: dcht_dma_model.sv
// Purpose: behavioural system DMA controller feeding host bytes on request
// Assumes: request sampled once per byte, strobe high between bytes
// Notes:   byte k carries k*37+11 so the bench can predict the drive stream
`timescale 1ns/1ns
module dcht_dma_model (
  input wire logic clk_i,
  input wire logic req_i,
  input wire logic run_i,
  input wire logic [7:0] end_at_i,
  output logic grant_n_o,
  output logic wr_n_o,
  output logic [7:0] data_o,
  output logic end_cnt_o,
  output int sent_o
);
  initial begin
    grant_n_o = 1'b1;
    wr_n_o = 1'b1;
    data_o = 8'h5a;
    end_cnt_o = 1'b0;
    sent_o = 0;
  end

  // ----------------------------------------------------------------
  // byte cycle
  // ----------------------------------------------------------------
  // stops serving when run drops; a lingering request is tolerated
  always @(posedge clk_i) begin
    if (req_i && run_i && (end_at_i == 8'h00 || sent_o < int'(end_at_i))) begin
      grant_n_o <= 1'b0;
      @(posedge clk_i);
      // grant and strobe low with a byte; end count only under grant
      wr_n_o <= 1'b0;
      data_o <= 8'(sent_o * 37 + 11);
      end_cnt_o <= (sent_o + 1 == int'(end_at_i));
      sent_o <= sent_o + 1;
      @(posedge clk_i);
      wr_n_o <= 1'b1;
      end_cnt_o <= 1'b0;
      @(posedge clk_i);
      grant_n_o <= 1'b1;
      // released bus: no stale value left on the data lines
      data_o <= ~data_o;
    end
  end
endmodule // dcht_dma_model

// File: tb_disk_ctrl_host_transfer_phases.sv
// Purpose: self-checking bench for the host transfer phase logic
// Assumes: DMA model on the host side, random drive-side stalls
// Notes:   bit 8 of a queued result byte masks it from comparison
`timescale 1ns/1ns
module tb_disk_ctrl_host_transfer_phases;
  import dcht_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic host_wr = 1'b0;
  logic host_rd = 1'b0;
  logic [7:0] host_data = 8'h00;
  logic [3:0] thr = 4'h0;
  logic read_done = 1'b0;
  logic drv_rdy = 1'b0;
  logic stall = 1'b0;
  logic run = 1'b0;
  logic [7:0] end_at = 8'h00;
  logic [7:0] res_data, drv_data, dma_data;
  logic ready, dir, busy, irq, dreq, drv_valid, grant_n, wr_n, end_cnt;
  logic [31:0] seed = 32'd70266;
  logic [8:0] exp_q[$];
  int sent, errors = 0, checks_done = 0, drv_cnt = 0, drv_real = 0;

  always #10 clk = ~clk;

  dcht_top #(.FIFO_DEPTH(16)) u_dut (.CLK_I(clk), .RST_N_I(rst_n), .HOST_WR_I(host_wr),
    .HOST_DATA_I(host_data), .HOST_RD_I(host_rd), .RES_DATA_O(res_data),
    .HOST_SERVICE_READY_O(ready), .TRANSFER_DIRECTION_O(dir), .COMMAND_IN_PROGRESS_O(busy),
    .INT_O(irq), .DMA_REQUEST_OUT_O(dreq), .DMA_GRANT_N_I(grant_n), .DMA_WR_N_I(wr_n),
    .DMA_DATA_I(dma_data), .TRANSFER_END_COUNT_I(end_cnt), .BUFFER_THRESHOLD_FIELD_I(thr),
    .READ_DONE_I(read_done), .DRV_DATA_O(drv_data), .DRV_VALID_O(drv_valid),
    .DRV_READY_I(drv_rdy));

  dcht_dma_model u_dma (.clk_i(clk), .req_i(dreq), .run_i(run), .end_at_i(end_at),
    .grant_n_o(grant_n), .wr_n_o(wr_n), .data_o(dma_data), .end_cnt_o(end_cnt),
    .sent_o(sent));

  function automatic logic [31:0] xs();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  task automatic check(input logic [7:0] got, input logic [7:0] exp, input string m);
    checks_done++;
    if (got !== exp) begin
      errors++;
      $display("unexpected at %0t: %s got %h want %h", $time, m, got, exp);
    end
  endtask

  task automatic wrap_up();
    $display("checks %0d errors %0d", checks_done, errors);
    if (errors == 0 && checks_done > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // drive side and monitors
  // ----------------------------------------------------------------
  always @(posedge clk) drv_rdy <= !stall && (xs() % 4 != 0);

  always @(posedge clk) begin
    if (rst_n && drv_valid === 1'b1 && drv_rdy === 1'b1) begin
      if (drv_real < sent) begin
        check(drv_data, 8'(drv_real * 37 + 11), "drive byte");
        drv_real <= drv_real + 1;
      end else begin
        check(drv_data, 8'h00, "drive padding");
      end
      drv_cnt <= drv_cnt + 1;
    end
  end

  always @(posedge clk) begin
    if (end_cnt === 1'b1 && grant_n === 1'b0) begin
      @(posedge clk);
      @(negedge clk);
      check({7'h0, dreq}, 8'h00, "request after end count");
    end
  end

  // ----------------------------------------------------------------
  // host tasks
  // ----------------------------------------------------------------
  task automatic wait_ph(input logic d, input int lim);
    int n;
    n = 0;
    @(negedge clk);
    while (!(ready === 1'b1 && dir === d) && n < lim) begin
      @(negedge clk);
      n++;
    end
    if (n >= lim) check(8'h00, 8'h01, "phase wait");
  endtask

  task automatic send(input logic [7:0] b);
    wait_ph(1'b0, 100);
    @(posedge clk);
    host_wr <= 1'b1;
    host_data <= b;
    @(posedge clk);
    host_wr <= 1'b0;
    @(negedge clk);
  endtask

  task automatic send_cmd(input logic [7:0] op, input logic [2:0] hd, input logic [7:0] c,
                          input logic [7:0] h, input logic [7:0] r, input logic [7:0] fin);
    logic [7:0] b[9];
    b = '{op, {5'h00, hd}, c, h, r, 8'h00, fin, 8'h1b, 8'hff};
    for (int i = 0; i < 9; i++) begin
      send(b[i]);
    end
  endtask

  task automatic collect(input logic irq_exp);
    logic [8:0] e;
    wait_ph(1'b1, 6000);
    check({7'h0, irq}, {7'h0, irq_exp}, "interrupt");
    check({7'h0, busy}, 8'h01, "busy in result");
    while (exp_q.size() > 0) begin
      e = exp_q.pop_front();
      wait_ph(1'b1, 50);
      if (!e[8]) check(res_data, e[7:0], "result byte");
      @(posedge clk);
      host_rd <= 1'b1;
      @(posedge clk);
      host_rd <= 1'b0;
    end
    wait_ph(1'b0, 20);
    check({6'h0, dir, busy}, 8'h00, "idle status");
  endtask

  task automatic write_cmd(input logic [7:0] r, input logic [7:0] fin, input logic [7:0] lim,
                           input logic go, input logic [7:0] st0, input logic [7:0] st1,
                           input logic hold);
    logic [31:0] v;
    int base;
    v = xs();
    drv_cnt = 0;
    @(posedge clk);
    end_at <= lim;
    run <= go;
    stall <= hold;
    thr <= v[3:0];
    send_cmd({v[7:6], 1'b0, v[8] ? OP_WRITE_DEL : OP_WRITE_DATA}, v[11:9], v[23:16],
             v[31:24], r, fin);
    @(negedge clk);
    check({7'h0, dreq}, 8'h01, "request at execution");
    if (hold) begin
      base = sent;
      repeat (300) @(negedge clk);
      check({7'h0, dreq}, 8'h00, "request when full");
      check(8'((sent - base >= 16 && sent - base <= 18) ? 1 : 0), 8'h01, "fill count");
      stall <= 1'b0;
      repeat (100) @(negedge clk);
      check({7'h0, sent - base > 18 ? 1'b1 : 1'b0}, 8'h01, "request again");
    end
    exp_q = '{{1'b0, st0 | {5'h00, v[11:9]}}, {1'b0, st1}, 9'h000, {1'b0, v[23:16]},
              {1'b0, v[31:24]}, {1'b0, r}, 9'h000};
    collect(1'b1);
    check(8'(drv_cnt), 8'h80, "sector length");
    run <= 1'b0;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    logic [7:0] bad[3];
    logic [31:0] v;
    bad = '{8'h1f, 8'h00, 8'h47};
    repeat (5) @(posedge clk);
    check({2'h0, ready, dir, busy, irq, dreq, drv_valid}, 8'h20, "reset status");
    rst_n <= 1'b1;
    foreach (bad[i]) begin
      send(bad[i]);
      exp_q.push_back({1'b0, RES_INVALID});
      collect(1'b0);
    end
    $display("test invalid done");
    for (int k = 0; k < 2; k++) begin
      v = xs();
      send_cmd({v[7:5], k ? OP_READ_DEL : OP_READ_DATA}, v[10:8], v[23:16], v[31:24],
               8'h04, 8'h09);
      repeat (20) @(negedge clk);
      check({6'h0, dreq, dir}, 8'h00, "read execution idle");
      @(posedge clk);
      read_done <= 1'b1;
      @(posedge clk);
      read_done <= 1'b0;
      exp_q = '{{6'h00, v[10:8]}, 9'h000, 9'h000, {1'b0, v[23:16]}, {1'b0, v[31:24]},
                9'h004, 9'h000};
      collect(1'b1);
    end
    $display("test read done");
    write_cmd(8'h01, 8'h09, 8'd40, 1'b1, 8'h00, 8'h00, 1'b0);
    $display("test end count done");
    write_cmd(8'h03, 8'h03, 8'h00, 1'b1, 8'h40, 8'h80, 1'b1);
    $display("test final sector done");
    write_cmd(8'h02, 8'h09, 8'h00, 1'b0, 8'h40, 8'h10, 1'b0);
    $display("test underrun done");
    wrap_up();
  end

  initial begin
    #(20 * 60000);
    errors++;
    wrap_up();
  end
endmodule // tb_disk_ctrl_host_transfer_phases
